// ---- rss_queue_classifier_tb.sv ----
`timescale 1ns/100ps
module rss_queue_classifier_tb;
  reg clk, rstn, csd, leg, exd, nxd, kwr, twr, pv;
  reg [1:0] qme;
  reg [15:0] en;
  reg [5:0] kidx;
  reg [7:0] kbyte, tdata;
  reg [6:0] tidx;
  reg [4:0] tcpu;
  reg [8:0] f;
  reg [3:0] wt;
  reg [127:0] sa, da, ha, ra;
  wire prdy, rv, rrdy, q, irq;
  wire [4:0] cpu;
  wire [31:0] h;
  wire [3:0] ht;
  integer n_errors, total_checks, i;
  localparam [319:0] KEY = 320'h6d5a56da255b0ec24167253d43a38fb0d0ca2bcbae7b30b477cb2da38030f20c6a42b73bbeac01fa;
  rssq_classifier uut (.i_clk(clk), .i_rstn(rstn), .i_ce(1'b1), .i_checksum_report_disable(csd),
    .i_queue_mode_enable(qme), .i_hash_enables(en), .i_v6_ext_header_hash_disable(exd),
    .i_v6_new_ext_hash_disable(nxd), .i_legacy_desc(leg), .i_key_wr(kwr), .i_key_idx(kidx),
    .i_key_byte(kbyte), .i_tbl_wr(twr), .i_tbl_idx(tidx), .i_tbl_data(tdata), .i_tbl_cpu(tcpu),
    .i_pkt_valid(pv), .o_pkt_ready(prdy), .i_is_ipv4(f[8]), .i_is_ipv6(f[7]), .i_is_tcp(f[6]),
    .i_tcp_parseable(f[5]), .i_is_fragment(f[4]), .i_v6_has_ext(f[3]), .i_v6_ext_parse_ok(f[2]),
    .i_v6_has_home(f[1]), .i_v6_has_rt2(f[0]), .i_src_addr(sa), .i_dst_addr(da),
    .i_home_addr(ha), .i_rt2_addr(ra), .i_src_port(16'h0aea), .i_dst_port(16'h06e6),
    .o_res_valid(rv), .i_res_ready(rrdy), .o_queue(q), .o_cpu(cpu), .o_hash(h),
    .o_hash_type(ht), .o_direct_irq(irq));
  rssq_desc_writer writer (.i_clk(clk), .i_rstn(rstn), .i_valid(rv), .i_wait(wt), .o_ready(rrdy));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // One packet: offer, wait for the result, compare, let the writer take it
  task send(input [8:0] fl, input [3:0] et, input [31:0] eh, input eq, input [4:0] ec);
    integer n;
    begin
      @(posedge clk);
      f <= fl;
      pv <= 1'b1;
      // With both options present the header addresses are hidden
      sa <= (fl[1:0] == 2'h3) ? 128'h0
          : fl[7] ? 128'h3ffe2501_02001fff_00000000_00000007 : 128'h420995bb;
      da <= (fl[1:0] == 2'h3) ? 128'h0
          : fl[7] ? 128'h3ffe2501_02000003_00000000_00000001 : 128'ha18e6450;
      @(negedge clk);
      chk("ready", 32'h1, {31'h0, prdy});
      @(posedge clk);
      pv <= 1'b0;
      @(negedge clk);
      chk("irq", {31'h0, csd && (qme != 2'h0) && !leg}, {31'h0, irq});
      n = 0;
      while (rv !== 1'b1 && n < 400) begin
        @(negedge clk);
        n = n + 1;
      end
      chk("valid", 32'h1, {31'h0, rv});
      chk("type", {28'h0, et}, {28'h0, ht});
      chk("hash", eh, h);
      chk("queue", {31'h0, eq}, {31'h0, q});
      chk("cpu", {27'h0, ec}, {27'h0, cpu});
      while (rv === 1'b1) @(negedge clk);
      @(posedge clk);
    end
  endtask
  task results;
    begin
      $display("mismatches %0d comparisons %0d", n_errors, total_checks);
      if (n_errors == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    #400000;
    n_errors = n_errors + 1;
    results;
  end
  initial begin
    n_errors = 0; total_checks = 0; rstn = 1'b0; csd = 1'b0; qme = 2'h0; en = 16'h001f;
    leg = 1'b0; exd = 1'b0; nxd = 1'b0; kwr = 1'b0; twr = 1'b0; pv = 1'b0; f = 9'h0; wt = 4'h0;
    sa = 128'h0; da = 128'h0; kidx = 6'h0; kbyte = 8'h0; tidx = 7'h0; tdata = 8'h0; tcpu = 5'h0;
    ha = 128'h3ffe2501_02001fff_00000000_00000007;
    ra = 128'h3ffe2501_02000003_00000000_00000001;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    // Reserved entry bits set on purpose; queue follows index bit 3
    for (i = 0; i < 128; i = i + 1) begin
      @(posedge clk);
      kwr <= (i < 40);
      kidx <= i[5:0];
      kbyte <= KEY[319 - 8 * (i % 40) -: 8];
      twr <= 1'b1;
      tidx <= i[6:0];
      tdata <= {i[3], 7'h7f};
      tcpu <= i[4:0];
    end
    @(posedge clk);
    kwr <= 1'b0;
    twr <= 1'b0;
    qme <= 2'h1;
    send(9'h160, 4'h0, 32'h0, 1'b0, 5'h0);
    csd <= 1'b1;
    qme <= 2'h0;
    send(9'h160, 4'h0, 32'h0, 1'b0, 5'h0);
    qme <= 2'h2;
    leg <= 1'b1;
    send(9'h160, 4'h0, 32'h0, 1'b0, 5'h0);
    leg <= 1'b0;
    send(9'h160, 4'h1, 32'h51ccc178, 1'b1, 5'h18);
    send(9'h170, 4'h2, 32'h323e8fc2, 1'b0, 5'h02);
    wt <= 4'h9;
    send(9'h0e0, 4'h3, 32'h40207d3d, 1'b1, 5'h1d);
    send(9'h083, 4'h4, 32'h2cc18cd5, 1'b0, 5'h15);
    send(9'h0e8, 4'h5, 32'h2cc18cd5, 1'b0, 5'h15);
    exd <= 1'b1;
    send(9'h0ec, 4'h5, 32'h2cc18cd5, 1'b0, 5'h15);
    exd <= 1'b0;
    nxd <= 1'b1;
    send(9'h0ee, 4'h5, 32'h2cc18cd5, 1'b0, 5'h15);
    nxd <= 1'b0;
    en <= 16'h0001;
    send(9'h100, 4'h0, 32'h0, 1'b0, 5'h0);
    en <= 16'h0002;
    twr <= 1'b1;
    tidx <= 7'h42;
    tdata <= 8'h80;
    tcpu <= 5'h07;
    @(posedge clk);
    twr <= 1'b0;
    send(9'h160, 4'h2, 32'h323e8fc2, 1'b1, 5'h07);
    results;
  end
endmodule // rss_queue_classifier_tb
bind rssq_classifier rssq_monitor mon (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce),
  .i_checksum_report_disable(i_checksum_report_disable), .i_legacy_desc(i_legacy_desc),
  .i_queue_mode_enable(i_queue_mode_enable), .i_hash_enables(i_hash_enables),
  .i_pkt_valid(i_pkt_valid), .o_pkt_ready(o_pkt_ready), .i_is_ipv4(i_is_ipv4),
  .i_is_tcp(i_is_tcp), .i_tcp_parseable(i_tcp_parseable), .i_is_fragment(i_is_fragment),
  .o_res_valid(o_res_valid), .i_res_ready(i_res_ready), .o_queue(o_queue),
  .o_direct_irq(o_direct_irq), .o_cpu(o_cpu), .o_hash(o_hash), .o_hash_type(o_hash_type));

// ---- rssq_classifier.v ----
// Function
// [RULE_01] Classification on only with checksum reporting disabled and queue mode nonzero.
// [RULE_02] Classification off sends every packet to queue 0.
// [RULE_03] Unparseable packets go to queue 0 with zero hash and zero CPU.
// [RULE_04] Full 32-bit hash goes to descriptor and feeds the table index.
// [RULE_05] A 4-bit hash type reports which variant was used.
// [RULE_06] Seven hash LSBs index 128 entries giving CPU number and queue bit.
// [RULE_07] Entry bit 7 selects the queue; bits 6 to 0 are reserved.
// [RULE_08] Software loads the whole table before enabling classification.
// [RULE_09] Table writes apply at any time, not aligned to packets.
// [RULE_10] No classification with legacy descriptors; enabled packets signal interrupt directly.
// [RULE_11] Variant enables come from command bits 31:16, any combination allowed.
// [RULE_12] IPv4: TCP variant first, else address-only variant, skipping disabled ones.
// [RULE_13] IPv6: TCP, then extension-aware, then plain variant, among enabled ones.
// [RULE_14] TCP only if protocol is TCP, parseable, and not a fragment.
// [RULE_15] Extension disable blocks TCP and extension variants when extensions exist.
// [RULE_16] New-extension disable blocks them with home option or type-2 routing.
// [RULE_17] Home option supplies source, type-2 routing supplies destination address.
// [RULE_18] Unparseable IPv6 extensions fall back to the plain IPv6 variant.
// [RULE_19] Keyed hash: each one-bit XORs key's top 32 bits; key shifts per bit.
// [RULE_20] Fields fed in packet order, MSB of first byte first.
// [RULE_21] IPv4: 12 bytes with TCP, 8 address bytes without.
// [RULE_22] IPv6: 36 bytes with TCP, 32 address bytes without.
// [RULE_23] Results presented together with a valid strobe until the writer accepts.
`timescale 1ns/100ps
`include "rssq_consts.vh"

module rssq_classifier (
  // Clock, reset, enable
  input  wire         i_clk,
  input  wire         i_rstn,
  input  wire         i_ce,
  // Configuration
  input  wire         i_checksum_report_disable,
  input  wire [1:0]   i_queue_mode_enable,
  input  wire [15:0]  i_hash_enables,
  input  wire         i_v6_ext_header_hash_disable,
  input  wire         i_v6_new_ext_hash_disable,
  input  wire         i_legacy_desc,
  // Secret key load
  input  wire         i_key_wr,
  input  wire [5:0]   i_key_idx,
  input  wire [7:0]   i_key_byte,
  // Redirection table load
  input  wire         i_tbl_wr,
  input  wire [6:0]   i_tbl_idx,
  input  wire [7:0]   i_tbl_data,
  input  wire [4:0]   i_tbl_cpu,
  // Parsed packet from the receive parser
  input  wire         i_pkt_valid,
  output wire         o_pkt_ready,
  input  wire         i_is_ipv4,
  input  wire         i_is_ipv6,
  input  wire         i_is_tcp,
  input  wire         i_tcp_parseable,
  input  wire         i_is_fragment,
  input  wire         i_v6_has_ext,
  input  wire         i_v6_ext_parse_ok,
  input  wire         i_v6_has_home,
  input  wire         i_v6_has_rt2,
  input  wire [127:0] i_src_addr,
  input  wire [127:0] i_dst_addr,
  input  wire [127:0] i_home_addr,
  input  wire [127:0] i_rt2_addr,
  input  wire [15:0]  i_src_port,
  input  wire [15:0]  i_dst_port,
  // Result to the descriptor writer
  output wire         o_res_valid,
  input  wire         i_res_ready,
  output reg          o_queue,
  output reg  [4:0]   o_cpu,
  output reg  [31:0]  o_hash,
  output reg  [3:0]   o_hash_type,
  output reg          o_direct_irq
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_HASH = 2'h1;
  localparam [1:0] ST_DONE = 2'h2;

  // Sequential state
  reg  [1:0]   state;
  reg  [319:0] kshift;
  reg  [287:0] din;
  reg  [8:0]   bits_left;
  reg  [31:0]  result;
  reg  [3:0]   htype;

  // Key and table storage, one driver per byte or entry
  wire [319:0] key;
  wire [127:0] tbl_q;
  wire [639:0] tbl_cpu;

  // Next values of the state and of the result outputs
  reg  [1:0]   next_state;
  reg  [319:0] next_kshift;
  reg  [287:0] next_din;
  reg  [8:0]   next_bits_left;
  reg  [31:0]  next_result;
  reg  [3:0]   next_htype;
  reg          next_queue;
  reg  [4:0]   next_cpu;
  reg  [31:0]  next_hash;
  reg  [3:0]   next_hash_type;
  reg          next_direct_irq;

  wire classify_on = i_checksum_report_disable && (i_queue_mode_enable != 2'b00)
                     && !i_legacy_desc; // RULE_01 RULE_10

  wire is_tcp_seg = i_is_tcp && i_tcp_parseable && !i_is_fragment; // RULE_14

  wire v6_blocked = (i_v6_ext_header_hash_disable && i_v6_has_ext) // RULE_15
                    || (i_v6_new_ext_hash_disable && (i_v6_has_home || i_v6_has_rt2)); // RULE_16

  // Extension-aware variants need the extension chain to be readable
  wire v6_ext_ok = !v6_blocked && (!i_v6_has_ext || i_v6_ext_parse_ok); // RULE_18

  wire [127:0] v6_src_ext = i_v6_has_home ? i_home_addr : i_src_addr; // RULE_17
  wire [127:0] v6_dst_ext = i_v6_has_rt2  ? i_rt2_addr  : i_dst_addr; // RULE_17

  // Conditions of each variant, ahead of the priority chain
  wire v4_tcp_hit = i_hash_enables[`RSSQ_EN_V4_TCP] && is_tcp_seg; // RULE_11 RULE_12
  wire v4_hit     = i_hash_enables[`RSSQ_EN_V4]; // RULE_11
  wire v6_tcp_hit = i_hash_enables[`RSSQ_EN_V6_TCP] && is_tcp_seg && v6_ext_ok; // RULE_13
  wire v6_ext_hit = i_hash_enables[`RSSQ_EN_V6_EXT] && v6_ext_ok; // RULE_13
  wire v6_hit     = i_hash_enables[`RSSQ_EN_V6]; // RULE_18

  // Hash inputs, first packet byte in the top bits, zero padded below
  wire [287:0] din_v4_tcp = {
    i_src_addr[31:0],
    i_dst_addr[31:0],
    i_src_port,
    i_dst_port,
    192'h0
  }; // RULE_20 RULE_21

  wire [287:0] din_v4 = {
    i_src_addr[31:0],
    i_dst_addr[31:0],
    224'h0
  }; // RULE_21

  wire [287:0] din_v6_tcp = {
    v6_src_ext,
    v6_dst_ext,
    i_src_port,
    i_dst_port
  }; // RULE_22

  wire [287:0] din_v6_ext = {
    v6_src_ext,
    v6_dst_ext,
    32'h0
  }; // RULE_17 RULE_22

  // Plain variant keeps the header addresses whatever options exist
  wire [287:0] din_v6 = {
    i_src_addr,
    i_dst_addr,
    32'h0
  }; // RULE_22

  reg [3:0]   sel_type;
  reg [287:0] sel_din;
  reg [8:0]   sel_bits;

  // Variant priority; a family with no usable variant stays unhashed
  always @* begin
    sel_type = `RSSQ_TYPE_NONE;
    sel_din  = {`RSSQ_IN_BITS{1'b0}};
    sel_bits = 9'h000;
    if (i_is_ipv4) begin
      if (v4_tcp_hit) begin // RULE_12
        sel_type = `RSSQ_TYPE_V4_TCP;
        sel_din  = din_v4_tcp;
        sel_bits = `RSSQ_BITS_V4_TCP;
      end else if (v4_hit) begin // RULE_12
        sel_type = `RSSQ_TYPE_V4;
        sel_din  = din_v4;
        sel_bits = `RSSQ_BITS_V4;
      end
    end else if (i_is_ipv6) begin
      if (v6_tcp_hit) begin // RULE_13
        sel_type = `RSSQ_TYPE_V6_TCP;
        sel_din  = din_v6_tcp;
        sel_bits = `RSSQ_BITS_V6_TCP;
      end else if (v6_ext_hit) begin // RULE_13
        sel_type = `RSSQ_TYPE_V6_EXT;
        sel_din  = din_v6_ext;
        sel_bits = `RSSQ_BITS_V6;
      end else if (v6_hit) begin // RULE_13 RULE_18
        sel_type = `RSSQ_TYPE_V6;
        sel_din  = din_v6;
        sel_bits = `RSSQ_BITS_V6;
      end
    end
  end

  assign o_pkt_ready = (state == ST_IDLE);
  assign o_res_valid = (state == ST_DONE); // RULE_23

  wire        accept      = i_ce && i_pkt_valid && o_pkt_ready;
  wire        hash_bit    = din[287];
  wire        last_bit    = (bits_left == 9'h001);
  wire [31:0] step_result = hash_bit ? (result ^ kshift[319:288]) : result; // RULE_19

  // Key bytes and table entries live in flops; byte 0 is the leftmost key byte
  genvar g;
  generate
    for (g = 0; g < `RSSQ_KEY_BYTES; g = g + 1) begin : g_key
      localparam [5:0] IDX = g;
      reg [7:0] kbyte;
      always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          kbyte <= 8'h00;
        end else if (i_ce && i_key_wr && (i_key_idx == IDX)) begin
          kbyte <= i_key_byte;
        end
      end
      assign key[319-8*g -: 8] = kbyte;
    end
    // No reset: contents are undefined until software loads them
    for (g = 0; g < `RSSQ_TBL_ENTRIES; g = g + 1) begin : g_tbl
      localparam [6:0] IDX = g;
      reg       qbit;
      reg [4:0] cpu_num;
      always @(posedge i_clk) begin
        if (i_ce && i_tbl_wr && (i_tbl_idx == IDX)) begin // RULE_09
          qbit    <= i_tbl_data[`RSSQ_TBL_QUEUE_BIT]; // RULE_07
          cpu_num <= i_tbl_cpu;
        end
      end
      assign tbl_q[g]          = qbit;
      assign tbl_cpu[5*g +: 5] = cpu_num;
    end
  endgenerate

  // Lookup reads the live table, so a write may land mid-packet
  wire [6:0] tbl_idx = step_result[6:0]; // RULE_06

  // Next-state and next-output decode
  always @* begin
    next_state      = state;
    next_kshift     = kshift;
    next_din        = din;
    next_bits_left  = bits_left;
    next_result     = result;
    next_htype      = htype;
    next_queue      = o_queue;
    next_cpu        = o_cpu;
    next_hash       = o_hash;
    next_hash_type  = o_hash_type;
    next_direct_irq = 1'b0;
    case (state)
      ST_IDLE: begin
        if (accept) begin
          next_direct_irq = classify_on; // RULE_10
          if (!classify_on || (sel_type == `RSSQ_TYPE_NONE)) begin
            next_queue     = 1'b0; // RULE_02 RULE_03
            next_cpu       = 5'h00; // RULE_03
            next_hash      = `RSSQ_RST_HASH; // RULE_03
            next_hash_type = `RSSQ_TYPE_NONE;
            next_state     = ST_DONE;
          end else begin
            next_kshift    = key;
            next_din       = sel_din;
            next_bits_left = sel_bits;
            next_result    = `RSSQ_RST_HASH;
            next_htype     = sel_type;
            next_state     = ST_HASH;
          end
        end
      end
      ST_HASH: begin
        // One input bit per cycle keeps the datapath to a 32-bit XOR
        next_result    = step_result; // RULE_19
        next_kshift    = {kshift[318:0], 1'b0}; // RULE_19
        next_din       = {din[286:0], 1'b0}; // RULE_20
        next_bits_left = bits_left - 9'h001;
        if (last_bit) begin
          next_hash      = step_result; // RULE_04
          next_queue     = tbl_q[tbl_idx]; // RULE_06 RULE_07
          next_cpu       = tbl_cpu[5*tbl_idx +: 5]; // RULE_06
          next_hash_type = htype; // RULE_05
          next_state     = ST_DONE;
        end
      end
      ST_DONE: begin
        if (i_res_ready) begin // RULE_23
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Control and hash state; everything holds while the clock enable is low
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state     <= ST_IDLE;
      kshift    <= `RSSQ_RST_KEY;
      din       <= {`RSSQ_IN_BITS{1'b0}};
      bits_left <= 9'h000;
      result    <= `RSSQ_RST_HASH;
      htype     <= `RSSQ_TYPE_NONE;
    end else if (i_ce) begin
      state     <= next_state;
      kshift    <= next_kshift;
      din       <= next_din;
      bits_left <= next_bits_left;
      result    <= next_result;
      htype     <= next_htype;
    end
  end

  // Result outputs come straight from flops; all but the o_direct_irq pulse stand while valid
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_queue      <= 1'b0;
      o_cpu        <= 5'h00;
      o_hash       <= `RSSQ_RST_HASH;
      o_hash_type  <= `RSSQ_TYPE_NONE;
      o_direct_irq <= 1'b0;
    end else if (i_ce) begin
      o_queue      <= next_queue;
      o_cpu        <= next_cpu;
      o_hash       <= next_hash;
      o_hash_type  <= next_hash_type;
      o_direct_irq <= next_direct_irq;
    end
  end

endmodule // rssq_classifier

// ---- rssq_consts.vh ----
`ifndef RSSQ_CONSTS_VH
`define RSSQ_CONSTS_VH

// Hash input lengths in bits
`define RSSQ_BITS_V4_TCP  9'h060
`define RSSQ_BITS_V4      9'h040
`define RSSQ_BITS_V6_TCP  9'h120
`define RSSQ_BITS_V6      9'h100

// Secret key and hash input widths
`define RSSQ_KEY_BYTES    40
`define RSSQ_KEY_BITS     320
`define RSSQ_IN_BITS      288

// Redirection table
`define RSSQ_TBL_ENTRIES  128
`define RSSQ_TBL_QUEUE_BIT 7

// Positions of the variant enables inside i_hash_enables (command bits 31:16)
`define RSSQ_EN_V4_TCP    0
`define RSSQ_EN_V4        1
`define RSSQ_EN_V6_TCP    2
`define RSSQ_EN_V6_EXT    3
`define RSSQ_EN_V6        4

// Hash type codes reported in the descriptor
`define RSSQ_TYPE_NONE    4'h0
`define RSSQ_TYPE_V4_TCP  4'h1
`define RSSQ_TYPE_V4      4'h2
`define RSSQ_TYPE_V6_TCP  4'h3
`define RSSQ_TYPE_V6_EXT  4'h4
`define RSSQ_TYPE_V6      4'h5

// Reset values
`define RSSQ_RST_HASH     32'h0000_0000
`define RSSQ_RST_KEY      320'h0

`endif

// ---- rssq_desc_writer.sv ----
`timescale 1ns/100ps
module rssq_desc_writer (
  input  wire       i_clk,
  input  wire       i_rstn,
  input  wire       i_valid,
  input  wire [3:0] i_wait,
  output reg        o_ready
);
  reg [3:0] cnt;
  // A slow writer stalls the result for i_wait cycles
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= 4'h0;
      o_ready <= 1'b0;
    end else if (i_valid && !o_ready && cnt >= i_wait) begin
      o_ready <= 1'b1;
    end else begin
      cnt <= (i_valid && !o_ready) ? cnt + 4'h1 : 4'h0;
      o_ready <= 1'b0;
    end
  end
endmodule // rssq_desc_writer

// ---- rssq_monitor.sv ----
`timescale 1ns/100ps
module rssq_monitor (
  input wire        i_clk, i_rstn, i_ce, i_checksum_report_disable, i_legacy_desc,
  input wire [1:0]  i_queue_mode_enable,
  input wire [15:0] i_hash_enables,
  input wire        i_pkt_valid, o_pkt_ready, i_is_ipv4, i_is_tcp, i_tcp_parseable,
  input wire        i_is_fragment, o_res_valid, i_res_ready, o_queue, o_direct_irq,
  input wire [4:0]  o_cpu,
  input wire [31:0] o_hash,
  input wire [3:0]  o_hash_type
);
  wire acc = i_ce & i_pkt_valid & o_pkt_ready;
  wire on  = i_checksum_report_disable & (|i_queue_mode_enable) & ~i_legacy_desc;
  wire v4t = i_is_ipv4 & i_is_tcp & i_tcp_parseable & ~i_is_fragment;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  busy_refuse_a: assert property (o_res_valid |-> !o_pkt_ready)
    else $error("packet ready while result held");
  result_hold_a: assert property (o_res_valid && !i_res_ready |=> o_res_valid
    && $stable(o_hash) && $stable(o_queue) && $stable(o_cpu) && $stable(o_hash_type))
    else $error("result moved");
  result_drop_a: assert property (o_res_valid && i_res_ready |=> !o_res_valid)
    else $error("result not released");
  unhashed_zero_a: assert property (o_res_valid && o_hash_type == 4'h0 |-> o_hash == 32'h0
    && o_cpu == 5'h0 && !o_queue) else $error("unhashed result not zero");
  off_fast_a: assert property (acc && !on |=> o_res_valid && o_hash_type == 4'h0
    && !o_direct_irq) else $error("disabled packet not answered at once");
  irq_pulse_a: assert property (acc && on |=> o_direct_irq ##1 !o_direct_irq)
    else $error("direct interrupt pulse wrong");
  v4_tcp_time_a: assert property (acc && on && v4t && i_hash_enables[0] |->
    ##96 !o_res_valid ##1 o_res_valid && o_hash_type == 4'h1) else $error("v4 tcp hash timing");
  v4_addr_time_a: assert property (acc && on && i_is_ipv4 && i_hash_enables[1]
    && !(v4t && i_hash_enables[0]) |-> ##64 !o_res_valid ##1 o_res_valid && o_hash_type == 4'h2)
    else $error("v4 address hash timing");
  type_known_a: assert property (o_res_valid |-> o_hash_type <= 4'h5)
    else $error("unknown hash type");
endmodule // rssq_monitor
